// ===== core/iob_map.svh
// Widths, field positions, encodings and reset values for the execution core.
`ifndef IOB_MAP_SVH
`define IOB_MAP_SVH

`define IOB_INSTR_W 14
`define IOB_PC_W 13
`define IOB_OP6_HI 13
`define IOB_OP6_LO 8
`define IOB_DEST_BIT 7
`define IOB_FADDR_HI 6
`define IOB_LIT_HI 7
`define IOB_K_HI 10
`define IOB_OP3_LO 11
`define IOB_LATCH_HI 4
`define IOB_LATCH_LO 3

`define IOB_OP_INCSZ 6'h0f
`define IOB_OP_INCREMENT_REGISTER 6'h0a
`define IOB_OP_ORWF 6'h04
`define IOB_OP_MOVE_REGISTER 6'h08
`define IOB_OP_ORLW 6'h38
`define IOB_OP_BRANCH 3'h5

`define IOB_DEST_ACC 1'h0
`define IOB_DEST_FILE 1'h1

`define IOB_RST_DATA 8'h00
`define IOB_RST_PC 13'h0000

`endif

// ===== core/iob_pkg.sv
// Types shared by the execution core.
package iob_pkg;
    typedef enum logic [1:0] {
        ST_EXEC,
        ST_SKIP_NOP,
        ST_BRANCH_NOP
    } iob_state_t;
endpackage

// ===== core/iob_core.sv
// Execution core for increment, skip, OR, move and branch instructions.
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`include "iob_map.svh"

module iob_core #(
    parameter int ADDR_W = 7,
    parameter int DATA_W = 8
) (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_clk_en,
    input wire logic [`IOB_INSTR_W-1:0] i_instr,
    input wire logic [4:0] i_upper_address_latch,
    input wire logic [ADDR_W-1:0] i_peek_addr,
    output logic [`IOB_PC_W-1:0] o_program_counter,
    output logic [DATA_W-1:0] o_accumulator,
    output logic o_zero_flag,
    output logic o_nop_slot,
    output logic [DATA_W-1:0] o_peek_data
);
    import iob_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;

    // The instruction word layout fixes both widths.
    generate
        if (ADDR_W != 7 || DATA_W != 8) begin : g_bad_width
            $error("iob_core supports only a 7-bit address and 8-bit data");
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] file_mem [DEPTH];
    logic [DATA_W-1:0] acc_reg;
    logic zero_reg;
    logic nop_reg;
    logic [`IOB_PC_W-1:0] pc_reg;
    logic [DATA_W-1:0] peek_reg;
    iob_state_t state_reg;

    logic [5:0] op6;
    logic dest;
    logic [ADDR_W-1:0] faddr;
    logic [DATA_W-1:0] lit;
    logic [10:0] kaddr;
    logic [DATA_W-1:0] fval;
    logic [DATA_W-1:0] inc_val;
    logic exec;
    logic is_incsz;
    logic is_increment_register;
    logic is_orwf;
    logic is_move_register;
    logic is_orlw;
    logic is_branch;
    logic [DATA_W-1:0] res_next;
    logic wr_acc;
    logic wr_file;
    logic wr_zero;
    logic [`IOB_PC_W-1:0] branch_target;

    assign op6 = i_instr[`IOB_OP6_HI:`IOB_OP6_LO];
    assign dest = i_instr[`IOB_DEST_BIT];
    assign faddr = i_instr[`IOB_FADDR_HI:0];
    assign lit = i_instr[`IOB_LIT_HI:0];
    assign kaddr = i_instr[`IOB_K_HI:0];
    assign fval = file_mem[faddr];
    assign inc_val = DATA_W'(fval + 1'b1);
    assign exec = (state_reg == ST_EXEC);
    assign is_incsz = exec && (op6 == `IOB_OP_INCSZ);
    assign is_increment_register = exec && (op6 == `IOB_OP_INCREMENT_REGISTER);
    assign is_orwf = exec && (op6 == `IOB_OP_ORWF);
    assign is_move_register = exec && (op6 == `IOB_OP_MOVE_REGISTER);
    assign is_orlw = exec && (op6 == `IOB_OP_ORLW);
    assign is_branch = exec && (i_instr[`IOB_OP6_HI:`IOB_OP3_LO] == `IOB_OP_BRANCH);
    assign branch_target = {i_upper_address_latch[`IOB_LATCH_HI:`IOB_LATCH_LO], kaddr};

    //////////////////////////////////////////////////////////////////////////
    // Unknown words and the discarded slot act as no_operation.
    always_comb begin
        res_next = `IOB_RST_DATA;
        wr_acc = 1'b0;
        wr_file = 1'b0;
        wr_zero = 1'b0;
        if (is_incsz || is_increment_register) begin
            res_next = inc_val;
            wr_acc = (dest == `IOB_DEST_ACC);
            wr_file = (dest == `IOB_DEST_FILE);
            wr_zero = is_increment_register;
        end else if (is_orwf || is_move_register) begin
            res_next = is_orwf ? (acc_reg | fval) : fval;
            wr_acc = (dest == `IOB_DEST_ACC);
            wr_file = (dest == `IOB_DEST_FILE);
            wr_zero = 1'b1;
        end else if (is_orlw) begin
            res_next = acc_reg | lit;
            wr_acc = 1'b1;
            wr_zero = 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // file write-back
    generate
        for (genvar gi = 0; gi < DEPTH; gi++) begin : g_file
            always_ff @(posedge i_clock) begin
                if (i_srst) begin
                    file_mem[gi] <= `IOB_RST_DATA;
                end else if (i_clk_en && wr_file && faddr == ADDR_W'(gi)) begin
                    file_mem[gi] <= res_next;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            acc_reg <= `IOB_RST_DATA;
        end else if (i_clk_en && wr_acc) begin
            acc_reg <= res_next;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            zero_reg <= 1'b0;
        end else if (i_clk_en && wr_zero) begin
            zero_reg <= (res_next == `IOB_RST_DATA);
        end
    end

    // The slot after a skip or branch holds a word that was fetched too early.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_reg <= ST_EXEC;
            nop_reg <= 1'b0;
        end else if (i_clk_en) begin
            unique case (state_reg)
                ST_EXEC: begin
                    if (is_branch) begin
                        state_reg <= ST_BRANCH_NOP;
                        nop_reg <= 1'b1;
                    end else if (is_incsz && inc_val == `IOB_RST_DATA) begin
                        state_reg <= ST_SKIP_NOP;
                        nop_reg <= 1'b1;
                    end
                end
                ST_SKIP_NOP, ST_BRANCH_NOP: begin
                    state_reg <= ST_EXEC;
                    nop_reg <= 1'b0;
                end
                default: begin
                    // Code 3 is never entered, so fall back to plain execution.
                    state_reg <= ST_EXEC;
                    nop_reg <= 1'b0;
                end
            endcase
        end
    end

    // A branch slot holds the counter so the target word is executed next.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            pc_reg <= `IOB_RST_PC;
        end else if (i_clk_en) begin
            if (is_branch) begin
                pc_reg <= branch_target;
            end else if (state_reg != ST_BRANCH_NOP) begin
                pc_reg <= `IOB_PC_W'(pc_reg + 1'b1);
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            peek_reg <= `IOB_RST_DATA;
        end else if (i_clk_en) begin
            peek_reg <= file_mem[i_peek_addr];
        end
    end

    assign o_program_counter = pc_reg;
    assign o_accumulator = acc_reg;
    assign o_zero_flag = zero_reg;
    assign o_nop_slot = nop_reg;
    assign o_peek_data = peek_reg;

    //////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_srst);

    sequence s_nop_slot;
        nop_reg && state_reg != ST_EXEC;
    endsequence

    sequence s_resume;
        !nop_reg && state_reg == ST_EXEC;
    endsequence

    a_incsz_acc_dest: assert property (
        i_clk_en && is_incsz && dest == 1'b0 |=> acc_reg == $past(inc_val))
        else $error("increment-skip did not load the accumulator");

    a_file_dest_write: assert property (
        i_clk_en && (is_incsz || is_increment_register) && dest == 1'b1
        |=> file_mem[$past(faddr)] == $past(inc_val) && $stable(acc_reg))
        else $error("increment did not write the file register");

    a_skip_two_cycles: assert property (
        i_clk_en && is_incsz && inc_val == 8'h00 ##1 i_clk_en
        |-> s_nop_slot ##1 s_resume)
        else $error("zero increment-skip did not take two cycles");

    a_skip_pc_step: assert property (
        i_clk_en && is_incsz && inc_val == 8'h00 ##1 i_clk_en
        |=> pc_reg == $past(pc_reg, 2) + 13'h0002)
        else $error("skipped word was not passed over");

    a_noskip_no_flags: assert property (
        i_clk_en && is_incsz && inc_val != 8'h00 |=> s_resume and $stable(zero_reg))
        else $error("non-zero increment-skip disturbed flow or flags");

    a_increment_register_zero_set: assert property (
        i_clk_en && is_increment_register |=> zero_reg == ($past(fval) == 8'hff) && !nop_reg)
        else $error("increment zero flag wrong");

    a_branch_target: assert property (
        i_clk_en && is_branch
        |=> pc_reg == {$past(i_upper_address_latch[4:3]), $past(kaddr)})
        else $error("branch target wrong");

    a_branch_two_cycles: assert property (
        i_clk_en && is_branch ##1 i_clk_en
        |-> (s_nop_slot and $stable(zero_reg)) ##1 (s_resume and $stable(pc_reg)))
        else $error("branch timing or flags wrong");

    a_orlit_result: assert property (
        i_clk_en && is_orlw |=> acc_reg == ($past(acc_reg) | $past(lit))
        && zero_reg == (acc_reg == 8'h00))
        else $error("OR-literal result wrong");

    a_orreg_result: assert property (
        i_clk_en && is_orwf && dest == 1'b0
        |=> acc_reg == ($past(acc_reg) | $past(fval)) && zero_reg == (acc_reg == 8'h00))
        else $error("OR-register result wrong");

    a_move_copy: assert property (
        i_clk_en && is_move_register && dest == 1'b0 |=> acc_reg == $past(fval))
        else $error("move did not copy into the accumulator");

    a_move_zero_test: assert property (
        i_clk_en && is_move_register && dest == 1'b1
        |=> zero_reg == ($past(fval) == 8'h00) && $stable(acc_reg) && !nop_reg)
        else $error("self move zero test wrong");

    a_move_self_keep: assert property (
        i_clk_en && is_move_register && dest == 1'b1 |=> file_mem[$past(faddr)] == $past(fval))
        else $error("self move altered the file register");

    a_single_cycle_ops: assert property (
        i_clk_en && (is_increment_register || is_orlw || is_orwf)
        |=> pc_reg == $past(pc_reg) + 13'h0001 && !nop_reg)
        else $error("single-cycle instruction did not advance by one");

    a_incr_wrap_zero: assert property (
        i_clk_en && is_increment_register && fval == 8'hff
        |=> zero_reg && (acc_reg == 8'h00 || file_mem[$past(faddr)] == 8'h00))
        else $error("increment of all ones did not wrap to zero");

    a_freeze_hold: assert property (
        !i_clk_en |=> $stable(pc_reg) && $stable(acc_reg) && $stable(zero_reg))
        else $error("state moved while the clock enable was low");
endmodule

// ===== tb/tb_top.sv
// Self-checking testbench for the execution core.
`timescale 1ns/10ps
`include "iob_map.svh"

module tb_top;
    logic i_clock;
    logic i_srst;
    logic i_clk_en;
    logic [13:0] i_instr;
    logic [4:0] i_upper_address_latch;
    logic [6:0] i_peek_addr;
    logic [12:0] o_program_counter;
    logic [7:0] o_accumulator;
    logic o_zero_flag;
    logic o_nop_slot;
    logic [7:0] o_peek_data;
    logic [12:0] exp_pc;
    int fails;
    int compares;

    iob_core DUT (.i_clock(i_clock), .i_srst(i_srst), .i_clk_en(i_clk_en),
        .i_instr(i_instr), .i_upper_address_latch(i_upper_address_latch),
        .i_peek_addr(i_peek_addr), .o_program_counter(o_program_counter),
        .o_accumulator(o_accumulator), .o_zero_flag(o_zero_flag),
        .o_nop_slot(o_nop_slot), .o_peek_data(o_peek_data));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [13:0] fw(input logic [5:0] op, input logic d,
                                       input logic [6:0] a);
        return {op, d, a};
    endfunction

    task automatic print_verdict;
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [12:0] e, input logic [12:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic ca(input logic [7:0] e);
        chk("acc", 13'(e), 13'(o_accumulator));
    endtask

    task automatic cz(input logic e);
        chk("zero", 13'(e), 13'(o_zero_flag));
    endtask

    task automatic cs(input logic e);
        chk("slot", 13'(e), 13'(o_nop_slot));
    endtask

    // Inputs change one nanosecond after the edge, so every edge sees them settled.
    task automatic edge1(input logic [13:0] w);
        i_instr = w;
        @(posedge i_clock);
        #1;
    endtask

    task automatic run(input logic [13:0] w);
        edge1(w);
        exp_pc = exp_pc + 13'h0001;
        chk("pc", exp_pc, o_program_counter);
        cs(1'b0);
    endtask

    // Two unknown words act as no_operation, so the file is quiet while peeked.
    task automatic peek(input logic [6:0] a, input logic [7:0] e);
        i_peek_addr = a;
        run(14'h0000);
        run(14'h0000);
        chk("file", 13'(e), 13'(o_peek_data));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // OR forms, then move, increment, skip and branch.
    task automatic t_or;
        run({`IOB_OP_ORLW, 8'h00});
        cz(1'b1);
        run({`IOB_OP_ORLW, 8'h5a});
        cz(1'b0);
        run({`IOB_OP_ORLW, 8'h81});
        ca(8'hdb);
        run(fw(`IOB_OP_ORWF, `IOB_DEST_FILE, 7'h03));
        ca(8'hdb);
        run(fw(`IOB_OP_MOVE_REGISTER, `IOB_DEST_ACC, 7'h05));
        ca(8'h00);
        cz(1'b1);
        run({`IOB_OP_ORLW, 8'h24});
        run(fw(`IOB_OP_ORWF, `IOB_DEST_ACC, 7'h03));
        ca(8'hff);
        cz(1'b0);
        peek(7'h03, 8'hdb);
    endtask

    task automatic t_move;
        run(fw(`IOB_OP_MOVE_REGISTER, `IOB_DEST_FILE, 7'h07));
        cz(1'b1);
        ca(8'hff);
        run(fw(`IOB_OP_MOVE_REGISTER, `IOB_DEST_FILE, 7'h03));
        cz(1'b0);
        peek(7'h03, 8'hdb);
    endtask

    task automatic t_inc;
        run(fw(`IOB_OP_ORWF, `IOB_DEST_FILE, 7'h06));
        run(fw(`IOB_OP_INCREMENT_REGISTER, `IOB_DEST_ACC, 7'h06));
        ca(8'h00);
        cz(1'b1);
        peek(7'h06, 8'hff);
        run(fw(`IOB_OP_INCREMENT_REGISTER, `IOB_DEST_FILE, 7'h03));
        cz(1'b0);
        peek(7'h03, 8'hdc);
    endtask

    task automatic t_skip;
        run({`IOB_OP_ORLW, 8'hff});
        run(fw(`IOB_OP_ORWF, `IOB_DEST_FILE, 7'h08));
        edge1(fw(`IOB_OP_INCSZ, `IOB_DEST_FILE, 7'h08));
        exp_pc = exp_pc + 13'h0002;
        cs(1'b1);
        cz(1'b0);
        edge1({`IOB_OP_ORLW, 8'h01});
        cs(1'b0);
        ca(8'hff);
        chk("pc", exp_pc, o_program_counter);
        peek(7'h08, 8'h00);
        run(fw(`IOB_OP_MOVE_REGISTER, `IOB_DEST_FILE, 7'h08));
        run(fw(`IOB_OP_INCSZ, `IOB_DEST_ACC, 7'h03));
        ca(8'hdd);
        cz(1'b1);
        peek(7'h03, 8'hdc);
    endtask

    task automatic t_branch(input logic [4:0] latch, input logic [10:0] k);
        i_upper_address_latch = latch;
        edge1({`IOB_OP_BRANCH, k});
        exp_pc = {latch[4:3], k};
        chk("pc", exp_pc, o_program_counter);
        cs(1'b1);
        edge1({`IOB_OP_ORLW, 8'h22});
        chk("pc", exp_pc, o_program_counter);
        cs(1'b0);
        ca(8'hdd);
        cz(1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    initial begin
        #200000;
        fails++;
        print_verdict;
    end

    initial begin
        i_srst = 1'b1;
        i_clk_en = 1'b1;
        i_instr = 14'h0000;
        i_upper_address_latch = 5'h00;
        i_peek_addr = 7'h00;
        fails = 0;
        compares = 0;
        exp_pc = 13'h0000;
        repeat (16) @(posedge i_clock);
        #1;
        i_srst = 1'b0;
        chk("pc", 13'h0000, o_program_counter);
        ca(8'h00);
        cz(1'b0);
        cs(1'b0);
        t_or;
        t_move;
        t_inc;
        t_skip;
        t_branch(5'h17, 11'h2a5);
        t_branch(5'h08, 11'h7ff);
        run({`IOB_OP_ORLW, 8'h00});
        // A low enable must freeze every state element.
        i_clk_en = 1'b0;
        edge1({`IOB_OP_ORLW, 8'h22});
        chk("pc", exp_pc, o_program_counter);
        ca(8'hdd);
        i_clk_en = 1'b1;
        i_srst = 1'b1;
        edge1({`IOB_OP_ORLW, 8'h22});
        i_srst = 1'b0;
        chk("pc", 13'h0000, o_program_counter);
        ca(8'h00);
        print_verdict;
    end
endmodule
